/* File: rtl/iommu_tlb_maint.sv */
// tlb flush, invalidation and domain permission control with apb access
`timescale 1ns/1ns

// Functional notes
// - flush bits clear walk, shared, per-master tlbs
// - flush bit reads 1 until its clear ends
// - flush stalls every new lookup
// - accepted lookups finish before flush starts
// - page invalidate address in bits 31:12
// - page invalidate mask in bits 31:12
// - page invalidate start bit self-clears when done
// - invalidation never stalls lookups
// - no ordering against concurrent same-address lookups
// - walk invalidate address in bits 31:20
// - walk invalidate start bit self-clears when done
// - domain 1 read/write deny bits per master
// - domain 0 bits read zero, always permit
// - domain index from entry bits 7:4
module iommu_tlb_maint
    import iommu_maint_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // lookup requests from the masters
    input  wire logic              lkp_valid,
    output logic                   lkp_ready,
    input  wire lookup_req_t       lkp_req,
    // lookup results
    output logic                   lkp_resp_valid,
    output lookup_resp_t           lkp_resp,
    // clear and invalidate commands to the tlbs and walk cache
    output logic [NUM_MASTERS-1:0] master_tlb_clear,
    output logic                   shared_tlb_clear,
    output logic                   walk_cache_clear,
    output logic                   page_inval_active,
    output page_inval_t            page_inval,
    output logic                   walk_inval_active,
    output logic [31:0]            walk_inval_address
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [NUM_FLUSH-1:0]  flush_q;
    logic [NUM_FLUSH-1:0]  flush_run_q;
    logic [NUM_FLUSH-1:0]  flush_set;
    logic [NUM_FLUSH-1:0]  flush_start;
    logic [NUM_FLUSH-1:0]  flush_done;
    logic [31:0]           inval_page_address_q;
    logic [31:0]           inval_page_mask_q;
    logic                  inval_page_start_q;
    logic [31:0]           walk_inval_address_q;
    logic                  walk_inval_start_q;
    logic [DOM_PERM_W-1:0] dom1_deny_q;
    logic                  page_busy;
    logic                  walk_busy;
    logic                  page_go;
    logic                  page_done;
    logic                  walk_go;
    logic                  walk_done;
    logic                  wr_en;
    logic                  rd_setup;
    logic [31:0]           rd_d;
    logic [31:0]           prdata_q;
    logic [31:0]           wmask;
    logic                  lkp_accept;
    logic                  lkp_deny;
    logic                  inflight;
    logic [LOOKUP_STAGES-1:0] pipe_valid_q;
    lookup_resp_t          pipe_q [LOOKUP_STAGES];

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic reg_known(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_FLUSH, OFS_PAGE_ADDR, OFS_PAGE_MASK, OFS_PAGE_START,
            OFS_WALK_ADDR, OFS_WALK_START, OFS_DOMAIN_PERM:
                reg_known = 1'b1;
            default:
                reg_known = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [31:0] msk);
        merge = (old & ~msk) | (wdat & msk);
    endfunction

    // ----------------------------------------------------------------
    // apb front end
    // ----------------------------------------------------------------
    // zero wait states; read data is captured in the setup cycle so
    // that prdata comes from a flop in the access cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !reg_known(paddr);
    assign wr_en    = psel && penable && pwrite && reg_known(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata   = prdata_q;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    always_comb begin
        rd_d = RESET_ZERO;
        case (paddr)
            OFS_FLUSH: begin
                rd_d[NUM_MASTERS-1:0]  = flush_q[NUM_MASTERS-1:0];
                rd_d[FLUSH_SHARED_BIT] = flush_q[NUM_MASTERS];
                rd_d[FLUSH_WALK_BIT]   = flush_q[NUM_MASTERS+1];
            end
            OFS_PAGE_ADDR:   rd_d = inval_page_address_q;
            OFS_PAGE_MASK:   rd_d = inval_page_mask_q;
            OFS_PAGE_START:  rd_d[START_BIT] = inval_page_start_q;
            OFS_WALK_ADDR:   rd_d = walk_inval_address_q;
            OFS_WALK_START:  rd_d[START_BIT] = walk_inval_start_q;
            // domain 0 half stays zero on read
            OFS_DOMAIN_PERM: rd_d[DOM1_MSB:DOM1_LSB] = dom1_deny_q;
            default:         rd_d = RESET_ZERO;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= RESET_ZERO;
        end else if (rd_setup) begin
            prdata_q <= rd_d;
        end
    end

    // ----------------------------------------------------------------
    // address, mask and permission registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            inval_page_address_q <= RESET_ZERO;
            inval_page_mask_q    <= RESET_ZERO;
            walk_inval_address_q <= RESET_ZERO;
        end else if (wr_en) begin
            if (paddr == OFS_PAGE_ADDR) begin
                inval_page_address_q[31:PAGE_LSB] <=
                    merge(inval_page_address_q, pwdata, wmask)
                        [31:PAGE_LSB];
            end
            if (paddr == OFS_PAGE_MASK) begin
                inval_page_mask_q[31:PAGE_LSB] <=
                    merge(inval_page_mask_q, pwdata, wmask)
                        [31:PAGE_LSB];
            end
            if (paddr == OFS_WALK_ADDR) begin
                walk_inval_address_q[31:WALK_LSB] <=
                    merge(walk_inval_address_q, pwdata, wmask)
                        [31:WALK_LSB];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dom1_deny_q <= '0;
        end else if (wr_en && paddr == OFS_DOMAIN_PERM) begin
            dom1_deny_q <= merge({2'b00, dom1_deny_q, 16'h0000}, pwdata,
                                 wmask)[DOM1_MSB:DOM1_LSB];
        end
    end

    // ----------------------------------------------------------------
    // flush engines
    // ----------------------------------------------------------------
    always_comb begin
        flush_set = '0;
        if (wr_en && paddr == OFS_FLUSH) begin
            flush_set[NUM_MASTERS-1:0] =
                pwdata[NUM_MASTERS-1:0] & {NUM_MASTERS{pstrb[0]}};
            flush_set[NUM_MASTERS]     =
                pwdata[FLUSH_SHARED_BIT] & pstrb[2];
            flush_set[NUM_MASTERS+1]   =
                pwdata[FLUSH_WALK_BIT] & pstrb[2];
        end
    end

    generate
        for (genvar i = 0; i < NUM_FLUSH; i++) begin : g_flush
            // a clear only begins once older lookups have drained
            assign flush_start[i] = flush_q[i] && !flush_run_q[i] &&
                                    !inflight;

            op_timer #(
                .CYCLES (FLUSH_CYCLES)
            ) u_flush_timer (
                .core_clk (core_clk),
                .resetn   (resetn),
                .start    (flush_start[i]),
                .busy     (),
                .done     (flush_done[i])
            );

            // a new set in the done cycle wins and restarts the clear
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    flush_q[i] <= 1'b0;
                end else begin
                    flush_q[i] <= (flush_q[i] && !flush_done[i]) ||
                                  flush_set[i];
                end
            end

            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    flush_run_q[i] <= 1'b0;
                end else if (flush_start[i]) begin
                    flush_run_q[i] <= 1'b1;
                end else if (flush_done[i]) begin
                    flush_run_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign master_tlb_clear = flush_run_q[NUM_MASTERS-1:0];
    assign shared_tlb_clear = flush_run_q[NUM_MASTERS];
    assign walk_cache_clear = flush_run_q[NUM_MASTERS+1];

    // ----------------------------------------------------------------
    // page invalidation
    // ----------------------------------------------------------------
    assign page_go = !page_busy && inval_page_start_q;

    op_timer #(
        .CYCLES (INVAL_CYCLES)
    ) u_page_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .start    (page_go),
        .busy     (page_busy),
        .done     (page_done)
    );

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            inval_page_start_q <= 1'b0;
        end else begin
            inval_page_start_q <= (inval_page_start_q && !page_done) ||
                (wr_en && paddr == OFS_PAGE_START && pstrb[0] &&
                 pwdata[START_BIT]);
        end
    end

    // address and mask are sampled as the run starts, so software may
    // load the next pair while this one is busy
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            page_inval <= '0;
        end else if (page_go) begin
            page_inval.page <= inval_page_address_q;
            page_inval.mask <= inval_page_mask_q;
        end
    end

    assign page_inval_active = page_busy;

    // ----------------------------------------------------------------
    // walk cache invalidation
    // ----------------------------------------------------------------
    assign walk_go = !walk_busy && walk_inval_start_q;

    op_timer #(
        .CYCLES (WALK_INVAL_CYCLES)
    ) u_walk_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .start    (walk_go),
        .busy     (walk_busy),
        .done     (walk_done)
    );

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            walk_inval_start_q <= 1'b0;
        end else begin
            walk_inval_start_q <= (walk_inval_start_q && !walk_done) ||
                (wr_en && paddr == OFS_WALK_START && pstrb[0] &&
                 pwdata[START_BIT]);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            walk_inval_address <= RESET_ZERO;
        end else if (walk_go) begin
            walk_inval_address <= walk_inval_address_q;
        end
    end

    assign walk_inval_active = walk_busy;

    // ----------------------------------------------------------------
    // lookup path
    // ----------------------------------------------------------------
    // only flushes gate the door; invalidations run beside traffic and
    // a same-address lookup may see either entry
    assign lkp_ready  = !(|flush_q);
    assign lkp_accept = lkp_valid && lkp_ready;
    assign inflight   = |pipe_valid_q;

    perm_check u_perm (
        .dom1_deny (dom1_deny_q),
        .master    (lkp_req.master),
        .write     (lkp_req.write),
        .l2_entry  (lkp_req.l2_entry),
        .deny      (lkp_deny)
    );

    // accepted lookups always walk the full pipe, even under a flush
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pipe_valid_q <= '0;
        end else begin
            pipe_valid_q <= {pipe_valid_q[LOOKUP_STAGES-2:0],
                             lkp_accept};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int s = 0; s < LOOKUP_STAGES; s++) begin
                pipe_q[s] <= '0;
            end
        end else begin
            pipe_q[0] <= '{master: lkp_req.master, write: lkp_req.write,
                           deny: lkp_deny};
            for (int s = 1; s < LOOKUP_STAGES; s++) begin
                pipe_q[s] <= pipe_q[s-1];
            end
        end
    end

    assign lkp_resp_valid = pipe_valid_q[LOOKUP_STAGES-1];
    assign lkp_resp       = pipe_q[LOOKUP_STAGES-1];

endmodule // iommu_tlb_maint

/* File: rtl/iommu_maint_pkg.sv */
// shared constants and carrier types of the tlb maintenance block
package iommu_maint_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS      = 50;
    localparam int unsigned FLUSH_TIME_NS      = 400;
    localparam int unsigned FLUSH_CYCLES       =
        (FLUSH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INVAL_TIME_NS      = 200;
    localparam int unsigned INVAL_CYCLES       =
        (INVAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WALK_INVAL_TIME_NS = 100;
    localparam int unsigned WALK_INVAL_CYCLES  =
        (WALK_INVAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOOKUP_STAGES      = 3;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W             = 12;
    localparam logic [11:0] OFS_FLUSH          = 12'h080;
    localparam logic [11:0] OFS_PAGE_ADDR      = 12'h090;
    localparam logic [11:0] OFS_PAGE_MASK      = 12'h094;
    localparam logic [11:0] OFS_PAGE_START     = 12'h098;
    localparam logic [11:0] OFS_WALK_ADDR      = 12'h0A0;
    localparam logic [11:0] OFS_WALK_START     = 12'h0A8;
    localparam logic [11:0] OFS_DOMAIN_PERM    = 12'h0B0;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int unsigned NUM_MASTERS        = 7;
    localparam int unsigned NUM_FLUSH          = 9;
    localparam int unsigned FLUSH_SHARED_BIT   = 16;
    localparam int unsigned FLUSH_WALK_BIT     = 17;
    localparam int unsigned START_BIT          = 0;
    localparam int unsigned PAGE_LSB           = 12;
    localparam int unsigned WALK_LSB           = 20;
    localparam int unsigned DOM1_LSB           = 16;
    localparam int unsigned DOM1_MSB           = 29;
    localparam int unsigned DOM_PERM_W         = 14;
    localparam int unsigned PTE_DOMAIN_LSB     = 4;
    localparam int unsigned PTE_DOMAIN_MSB     = 7;
    localparam logic [3:0]  DOMAIN_FREE        = 4'h0;
    localparam logic [3:0]  DOMAIN_ONE         = 4'h1;
    localparam logic [31:0] RESET_ZERO         = 32'h00000000;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  master;
        logic        write;
        logic [31:0] l2_entry;
    } lookup_req_t;

    typedef struct packed {
        logic [2:0]  master;
        logic        write;
        logic        deny;
    } lookup_resp_t;

    typedef struct packed {
        logic [31:0] page;
        logic [31:0] mask;
    } page_inval_t;

endpackage

/* File: rtl/op_timer.sv */
// fixed-length operation timer: busy for a set count, with a done pulse in the last busy cycle
`timescale 1ns/1ns
module op_timer #(
    parameter int unsigned CYCLES = 1
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;

    // ----------------------------------------------------------------
    // countdown
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (start && cnt_q == '0) begin
            cnt_q <= CW'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == CW'(1));
endmodule // op_timer

/* File: rtl/perm_check.sv */
// domain permission check for one lookup
`timescale 1ns/1ns
module perm_check
    import iommu_maint_pkg::*;
(
    // domain 1 deny bits, read on even and write on odd positions
    input  wire logic [DOM_PERM_W-1:0] dom1_deny,
    // access
    input  wire logic [2:0]            master,
    input  wire logic                  write,
    input  wire logic [31:0]           l2_entry,
    // result
    output logic                       deny
);
    logic [3:0] domain;
    logic [3:0] idx;

    // the domain index lives in the second-level entry
    assign domain = l2_entry[PTE_DOMAIN_MSB:PTE_DOMAIN_LSB];
    assign idx    = {master, write};

    // ----------------------------------------------------------------
    // decision
    // ----------------------------------------------------------------
    always_comb begin
        deny = 1'b0;
        case (domain)
            DOMAIN_FREE: deny = 1'b0;
            DOMAIN_ONE: begin
                // master 7 does not exist, never deny it
                if (idx < 4'(DOM_PERM_W)) begin
                    deny = dom1_deny[idx];
                end
            end
            // other domains are not held here and stay unlimited
            default: deny = 1'b0;
        endcase
    end
endmodule // perm_check

/* File: tb/iommu_tlb_maint_monitor.sv */
// assertion checker for the tlb maintenance block
`timescale 1ns/1ns
module iommu_tlb_maint_monitor
    import iommu_maint_pkg::*;
(
    // clock, reset and apb
    input wire logic                   core_clk,
    input wire logic                   resetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [ADDR_W-1:0]      paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    // lookups and maintenance outputs
    input wire logic                   lkp_valid,
    input wire logic                   lkp_ready,
    input wire logic                   lkp_resp_valid,
    input wire logic [NUM_MASTERS-1:0] master_tlb_clear,
    input wire logic                   shared_tlb_clear,
    input wire logic                   walk_cache_clear,
    input wire logic                   page_inval_active,
    input wire page_inval_t            page_inval,
    input wire logic                   walk_inval_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // apb write of bit 0 at an offset
    sequence s_start(logic [11:0] a);
        psel && penable && pwrite && paddr == a && pstrb[0] && pwdata[0];
    endsequence
    sequence s_take;
        lkp_valid && lkp_ready;
    endsequence
    chk_flush_stall: assert property (s_start(OFS_FLUSH) |=> !lkp_ready)
        else $error("lookup open after flush");
    chk_busy_stall: assert property (
        (|master_tlb_clear || shared_tlb_clear || walk_cache_clear)
        |-> !lkp_ready)
        else $error("lookup open while a clear runs");
    chk_resp_time: assert property (s_take |-> ##3 lkp_resp_valid)
        else $error("lookup response missing");
    chk_resp_cause: assert property (
        lkp_resp_valid |-> $past(lkp_valid && lkp_ready, 3))
        else $error("response without lookup");
    chk_shared_len: assert property ($rose(shared_tlb_clear)
        |-> shared_tlb_clear [*8] ##1 !shared_tlb_clear)
        else $error("shared clear length wrong");
    chk_walk_len: assert property ($rose(walk_cache_clear)
        |-> walk_cache_clear [*8] ##1 !walk_cache_clear)
        else $error("walk cache clear length wrong");
    chk_page_len: assert property ($rose(page_inval_active)
        |-> page_inval_active [*4] ##1 !page_inval_active)
        else $error("page inval length wrong");
    chk_walkinv_len: assert property ($rose(walk_inval_active)
        |-> walk_inval_active [*2] ##1 !walk_inval_active)
        else $error("walk inval length wrong");
    chk_inval_flow: assert property (
        s_start(OFS_PAGE_START) ##0 lkp_ready |=> lkp_ready)
        else $error("invalidation stalled lookups");
    chk_page_align: assert property ($rose(page_inval_active)
        |-> page_inval.page[11:0] == 0 && page_inval.mask[11:0] == 0)
        else $error("page inval not aligned");
endmodule // iommu_tlb_maint_monitor

bind iommu_tlb_maint iommu_tlb_maint_monitor i_mon (.core_clk, .resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .lkp_valid,
    .lkp_ready, .lkp_resp_valid, .master_tlb_clear, .shared_tlb_clear,
    .walk_cache_clear, .page_inval_active, .page_inval, .walk_inval_active);

/* File: tb/lookup_master.sv */
// behavioural bus master that issues lookups
`timescale 1ns/1ns
module lookup_master
    import iommu_maint_pkg::*;
(
    // clock
    input  wire logic   core_clk,
    // lookup handshake
    output logic        lkp_valid,
    input  wire logic   lkp_ready,
    output lookup_req_t lkp_req
);
    initial begin
        lkp_valid = 1'b0;
        lkp_req   = '0;
    end
    // call just after a rising edge; holds until taken
    task automatic send(input lookup_req_t r);
        lkp_valid <= 1'b1;
        lkp_req   <= r;
        do @(posedge core_clk); while (lkp_ready !== 1'b1);
        lkp_valid <= 1'b0;
        // idle bus shows no stale request
        lkp_req   <= ~r;
    endtask
endmodule // lookup_master

/* File: tb/iommu_tlb_maint_bench.sv */
// self-checking bench for the tlb maintenance block
`timescale 1ns/1ns
module iommu_tlb_maint_bench import iommu_maint_pkg::*;;
    logic                   core_clk, resetn, psel, penable, pwrite;
    logic [ADDR_W-1:0]      paddr;
    logic [31:0]            pwdata, prdata, rd;
    logic [3:0]             pstrb;
    logic                   pready, pslverr, er, lkp_valid, lkp_ready;
    logic                   lkp_resp_valid, shared_tlb_clear;
    logic                   walk_cache_clear, page_inval_active;
    logic                   walk_inval_active;
    logic [NUM_MASTERS-1:0] master_tlb_clear;
    lookup_req_t            lkp_req;
    lookup_resp_t           lkp_resp;
    page_inval_t            page_inval;
    logic [31:0]            walk_inval_address;
    int                     fails, comparisons;
    logic [11:0] ofs[7] = '{OFS_FLUSH, OFS_PAGE_ADDR, OFS_PAGE_MASK,
        OFS_PAGE_START, OFS_WALK_ADDR, OFS_WALK_START, OFS_DOMAIN_PERM};
    logic [11:0] rw[4] = '{OFS_PAGE_ADDR, OFS_PAGE_MASK, OFS_WALK_ADDR,
        OFS_DOMAIN_PERM};
    logic [31:0] rwm[4] = '{32'hFFFFF000, 32'hFFFFF000, 32'hFFF00000,
        32'h3FFF0000};
    iommu_tlb_maint i_iommu_tlb_maint (.core_clk, .resetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
        .lkp_valid, .lkp_ready, .lkp_req, .lkp_resp_valid, .lkp_resp,
        .master_tlb_clear, .shared_tlb_clear, .walk_cache_clear,
        .page_inval_active, .page_inval, .walk_inval_active,
        .walk_inval_address);
    lookup_master i_lookup_master (.core_clk, .lkp_valid, .lkp_ready,
        .lkp_req);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // apb master and checks
    // ------------------------------------------------------------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // bounded poll of self-clearing bits
    task automatic poll(logic [11:0] a, logic [31:0] m);
        int n = 0;
        do begin
            apb(1'b0, a, '0);
            n++;
        end while ((rd & m) != 0 && n < 40);
        chk("poll", '0, rd & m);
    endtask
    task automatic finish_test;
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], '0);
            chk("reset value", '0, rd);
        end
        foreach (rw[i]) begin
            apb(1'b1, rw[i], 32'hFFFFFFFF);
            apb(1'b0, rw[i], '0);
            chk("rw bits", rwm[i], rd);
        end
        apb(1'b1, 12'h084, 32'hFFFFFFFF);
        chk("unmapped err", 32'h1, {31'h0, er});
        // invalidations run beside traffic
        apb(1'b1, OFS_PAGE_ADDR, 32'h12345ABC);
        apb(1'b1, OFS_PAGE_MASK, 32'hFFFF0FFF);
        apb(1'b1, OFS_PAGE_START, 32'h1);
        @(negedge core_clk);
        chk("page active", 32'h1, {31'h0, page_inval_active});
        chk("page addr", 32'h12345000, page_inval.page);
        chk("page mask", 32'hFFFF0000, page_inval.mask);
        chk("ready", 32'h1, {31'h0, lkp_ready});
        @(posedge core_clk);
        poll(OFS_PAGE_START, 32'h1);
        apb(1'b1, OFS_WALK_ADDR, 32'hABCDEFFF);
        apb(1'b1, OFS_WALK_START, 32'h1);
        @(negedge core_clk);
        chk("walk active", 32'h1, {31'h0, walk_inval_active});
        chk("walk addr", 32'hABC00000, walk_inval_address);
        @(posedge core_clk);
        poll(OFS_WALK_START, 32'h1);
        // flush with a lookup already in flight
        i_lookup_master.send('{3'd2, 1'b0, 32'h0});
        apb(1'b1, OFS_FLUSH, 32'h00030041);
        chk("stall", '0, {31'h0, lkp_ready});
        apb(1'b0, OFS_FLUSH, '0);
        chk("flush bits", 32'h00030041, rd);
        chk("clears", 32'h107, {master_tlb_clear, shared_tlb_clear,
            walk_cache_clear});
        i_lookup_master.send('{3'd6, 1'b1, 32'h0});
        chk("after flush", '0, {master_tlb_clear, shared_tlb_clear});
        apb(1'b1, OFS_FLUSH, 32'h00010000);
        apb(1'b1, OFS_FLUSH, 32'h00000001);
        repeat (3) @(posedge core_clk);
        poll(OFS_FLUSH, 32'h00010000);
        chk("flush alone", 32'h1, rd);
        poll(OFS_FLUSH, 32'h1);
        // deny per master, direction and domain
        apb(1'b1, OFS_DOMAIN_PERM, 32'h1B6C0000);
        for (int m = 0; m < 7; m++)
            for (int w = 0; w < 2; w++)
                for (int d = 0; d < 3; d++) begin
                    @(posedge core_clk);
                    i_lookup_master.send('{m[2:0], w[0],
                        32'hFFFFFF0F | (d << 4)});
                    repeat (2) @(posedge core_clk);
                    @(negedge core_clk);
                    chk("resp", {26'h0, 1'b1, m[2:0], w[0],
                        d == 1 && pwdata[16+2*m+w]},
                        {26'h0, lkp_resp_valid, lkp_resp});
                end
        finish_test();
    end
    initial begin
        #2000000;
        fails++;
        finish_test();
    end
endmodule // iommu_tlb_maint_bench
